//--- prog_port.sv
// Package and top module of the parallel memory programming port
// Assumes all pins already synchronous to i_clock; memories are plain arrays
`default_nettype none

package prog_port_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned ENTRY_HOLD_NS = 100;
	localparam logic [2:0] ENTRY_HOLD_CYCLES =
		3'((ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] SETTLE_CYCLES = 8'h10;

	localparam int unsigned FLASH_WORDS   = 8192;
	localparam int unsigned EE_BYTES      = 512;
	localparam int unsigned PAGE_WORDS    = 64;
	localparam int unsigned EE_PAGE_BYTES = 4;
	localparam logic [12:0] FLASH_LAST    = 13'h1fff;
	localparam logic [12:0] EE_LAST       = 13'h01ff;
	localparam logic [12:0] PAGE_LAST     = 13'h003f;
	localparam logic [12:0] EE_PAGE_LAST  = 13'h0003;

	localparam logic [7:0] CMD_CHIP_ERASE  = 8'h80;
	localparam logic [7:0] CMD_WRITE_FUSE  = 8'h40;
	localparam logic [7:0] CMD_WRITE_LOCK  = 8'h20;
	localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
	localparam logic [7:0] CMD_WRITE_EE    = 8'h11;
	localparam logic [7:0] CMD_READ_SIG    = 8'h08;
	localparam logic [7:0] CMD_READ_FUSE   = 8'h04;
	localparam logic [7:0] CMD_READ_FLASH  = 8'h02;
	localparam logic [7:0] CMD_READ_EE     = 8'h03;

	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;

	localparam logic [7:0]  FUSE_LO_RESET  = 8'he1;
	localparam logic [7:0]  FUSE_HI_RESET  = 8'h99;
	localparam logic [7:0]  LOCK_RESET     = 8'hff;
	localparam logic [7:0]  ERASED_BYTE    = 8'hff;
	localparam logic [15:0] ERASED_WORD    = 16'hffff;
	localparam int unsigned FUSE_EEPROM_PRESERVE_FUSE_BIT = 3;
	localparam int unsigned FIFO_WIDTH      = 23;
	localparam int unsigned FIFO_DEPTH      = 8;

	typedef enum logic [2:0] {
		ST_IDLE       = 3'h0,
		ST_ERASE_FL   = 3'h1,
		ST_ERASE_EE   = 3'h3,
		ST_ERASE_LOCK = 3'h2,
		ST_PROG       = 3'h6,
		ST_SETTLE     = 3'h7
	} op_state_t;
endpackage

`timescale 1ns/100ps

module prog_port
	import prog_port_pkg::*;
#(
	parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identity value
	parameter logic [7:0] SIG_BYTE1 = 8'ha5, // Arbitrary identity value
	parameter logic [7:0] SIG_BYTE2 = 8'h3c, // Arbitrary identity value
	parameter logic [7:0] CAL_BYTE0 = 8'h80,
	parameter logic [7:0] CAL_BYTE1 = 8'h81,
	parameter logic [7:0] CAL_BYTE2 = 8'h82,
	parameter logic [7:0] CAL_BYTE3 = 8'h83
) (
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_sys_rst,
	// Mode entry
	input  wire logic       i_high_voltage_reset,
	// Strobes and selects
	input  wire logic       i_crystal_input_strobe,
	input  wire logic       i_action_select_bit0,
	input  wire logic       i_action_select_bit1,
	input  wire logic       i_byte_select_low_high,
	input  wire logic       i_byte_select_extended,
	input  wire logic       i_page_load_strobe,
	input  wire logic       i_write_n,
	input  wire logic       i_output_enable_n,
	// Data bus pin
	input  wire logic [7:0] i_data_in,
	output logic      [7:0] o_data_out,
	output logic            o_data_oe,
	// Status
	output logic            o_ready_busy,
	output logic            o_programming_mode
);
	typedef struct packed {
		logic            mode;
		logic            entry_run;
		logic [2:0]      entry_cnt;
		logic            hv_d;
		logic            xtal_d;
		logic            wr_d;
		logic            pl_d;
		logic [7:0]      cmd;
		logic [7:0]      addr_hi;
		logic [7:0]      addr_lo;
		logic [7:0]      data_lo;
		logic [7:0]      data_hi;
		op_state_t       st;
		logic            ee_op;
		logic [12:0]     idx;
		logic [7:0]      settle;
		logic [7:0]      fuse_lo;
		logic [7:0]      fuse_hi;
		logic [7:0]      lock;
		logic            ready_busy;
		logic [7:0]      data_out;
		logic            data_oe;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	logic [15:0] flash_mem  [FLASH_WORDS];
	logic [7:0]  ee_mem     [EE_BYTES];
	logic [15:0] flash_page [PAGE_WORDS];
	logic [7:0]  ee_page    [EE_PAGE_BYTES];

	logic [1:0]            act;
	logic [3:0]            entry_pins;
	logic                  busy;
	logic                  xtal_ok;
	logic                  pl_ok;
	logic                  wr_ok;
	logic                  preserve_ee;
	logic [12:0]           flash_addr;
	logic [8:0]            ee_addr;
	logic [7:0]            rd_byte;
	logic                  fifo_in_valid;
	logic                  fifo_in_ready;
	logic [FIFO_WIDTH-1:0] fifo_in_data;
	logic                  fifo_out_valid;
	logic                  fifo_out_ready;
	logic [FIFO_WIDTH-1:0] fifo_out_data;
	logic                  flash_we;
	logic [12:0]           flash_waddr;
	logic [15:0]           flash_wdata;
	logic                  ee_we;
	logic [8:0]            ee_waddr;
	logic [7:0]            ee_wdata;

	assign act         = {i_action_select_bit1, i_action_select_bit0};
	assign entry_pins  = {i_page_load_strobe, act, i_byte_select_low_high};
	assign busy        = (s_r.st != ST_IDLE);
	assign xtal_ok     = s_r.mode && !busy && i_crystal_input_strobe && !s_r.xtal_d;
	assign pl_ok       = s_r.mode && !busy && i_page_load_strobe && !s_r.pl_d;
	assign wr_ok       = s_r.mode && !busy && !fifo_out_valid && !i_write_n && s_r.wr_d;
	assign preserve_ee = !s_r.fuse_hi[FUSE_EEPROM_PRESERVE_FUSE_BIT];
	assign flash_addr  = {s_r.addr_hi[4:0], s_r.addr_lo};
	assign ee_addr     = {s_r.addr_hi[0], s_r.addr_lo};

	// Page load into the staging FIFO
	always_comb begin
		fifo_in_valid = pl_ok && ((s_r.cmd == CMD_WRITE_FLASH && i_byte_select_low_high)
			|| s_r.cmd == CMD_WRITE_EE);
		if (s_r.cmd == CMD_WRITE_EE) begin
			fifo_in_data = {1'b1, 4'h0, s_r.addr_lo[1:0], 8'h00, s_r.data_lo};
		end else begin
			fifo_in_data = {1'b0, s_r.addr_lo[5:0], s_r.data_hi, s_r.data_lo};
		end
	end

	assign fifo_out_ready = !busy;

	prog_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clock     (i_clock),
		.i_sys_rst   (i_sys_rst),
		.i_in_valid  (fifo_in_valid),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_in_data),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_out_ready),
		.o_out_data  (fifo_out_data)
	);

	// Readback selection
	always_comb begin
		rd_byte = ERASED_BYTE;
		unique case (s_r.cmd)
			CMD_READ_FLASH: rd_byte = i_byte_select_low_high ? flash_mem[flash_addr][15:8]
				: flash_mem[flash_addr][7:0];
			CMD_READ_EE: rd_byte = ee_mem[ee_addr];
			CMD_READ_FUSE: begin
				unique case ({i_byte_select_extended, i_byte_select_low_high})
					2'h0: rd_byte = s_r.fuse_lo;
					2'h3: rd_byte = s_r.fuse_hi;
					2'h1: rd_byte = s_r.lock;
					2'h2: rd_byte = ERASED_BYTE;
				endcase
			end
			CMD_READ_SIG: begin
				if (i_byte_select_low_high) begin
					unique case (s_r.addr_lo[1:0])
						2'h0: rd_byte = CAL_BYTE0;
						2'h1: rd_byte = CAL_BYTE1;
						2'h2: rd_byte = CAL_BYTE2;
						2'h3: rd_byte = CAL_BYTE3;
					endcase
				end else if (s_r.addr_lo == 8'h00) begin
					rd_byte = SIG_BYTE0;
				end else if (s_r.addr_lo == 8'h01) begin
					rd_byte = SIG_BYTE1;
				end else if (s_r.addr_lo == 8'h02) begin
					rd_byte = SIG_BYTE2;
				end
			end
			default: rd_byte = ERASED_BYTE;
		endcase
	end

	// Memory write ports
	always_comb begin
		flash_we    = (s_r.st == ST_ERASE_FL) || (s_r.st == ST_PROG && !s_r.ee_op);
		flash_waddr = (s_r.st == ST_ERASE_FL) ? s_r.idx
			: {flash_addr[12:6], s_r.idx[5:0]};
		flash_wdata = (s_r.st == ST_ERASE_FL) ? ERASED_WORD : flash_page[s_r.idx[5:0]];
		ee_we       = (s_r.st == ST_ERASE_EE) || (s_r.st == ST_PROG && s_r.ee_op);
		ee_waddr    = (s_r.st == ST_ERASE_EE) ? s_r.idx[8:0] : {ee_addr[8:2], s_r.idx[1:0]};
		ee_wdata    = (s_r.st == ST_ERASE_EE) ? ERASED_BYTE : ee_page[s_r.idx[1:0]];
	end

	always_ff @(posedge i_clock) begin
		if (flash_we) begin
			flash_mem[flash_waddr] <= flash_wdata;
		end
		if (ee_we) begin
			ee_mem[ee_waddr] <= ee_wdata;
		end
		if (fifo_out_valid && fifo_out_ready && !fifo_out_data[22]) begin
			flash_page[fifo_out_data[21:16]] <= fifo_out_data[15:0];
		end
		if (fifo_out_valid && fifo_out_ready && fifo_out_data[22]) begin
			ee_page[fifo_out_data[17:16]] <= fifo_out_data[7:0];
		end
	end

	// Next state
	always_comb begin
		s_nxt        = s_r;
		s_nxt.hv_d   = i_high_voltage_reset;
		s_nxt.xtal_d = i_crystal_input_strobe;
		s_nxt.wr_d   = i_write_n;
		s_nxt.pl_d   = i_page_load_strobe;

		if (!i_high_voltage_reset) begin
			s_nxt.mode      = 1'b0;
			s_nxt.entry_run = 1'b0;
		end else if (!s_r.hv_d) begin
			s_nxt.entry_run = (entry_pins == 4'h0);
			s_nxt.entry_cnt = 3'h0;
		end else if (s_r.entry_run) begin
			if (entry_pins != 4'h0) begin
				s_nxt.entry_run = 1'b0;
			end else if (s_r.entry_cnt == ENTRY_HOLD_CYCLES - 3'h1) begin
				s_nxt.entry_run = 1'b0;
				s_nxt.mode      = 1'b1;
			end else begin
				s_nxt.entry_cnt = s_r.entry_cnt + 3'h1;
			end
		end

		if (xtal_ok) begin
			unique case (act)
				ACT_ADDR: begin
					if (i_byte_select_low_high) begin
						s_nxt.addr_hi = i_data_in;
					end else begin
						s_nxt.addr_lo = i_data_in;
					end
				end
				ACT_DATA: begin
					if (i_byte_select_low_high) begin
						s_nxt.data_hi = i_data_in;
					end else begin
						s_nxt.data_lo = i_data_in;
					end
				end
				ACT_CMD: s_nxt.cmd = i_data_in;
				2'h3: s_nxt.cmd = s_r.cmd;
			endcase
		end

		unique case (s_r.st)
			ST_IDLE: begin
				s_nxt.idx    = 13'h0000;
				s_nxt.settle = 8'h00;
				if (wr_ok) begin
					unique case (s_r.cmd)
						CMD_CHIP_ERASE: s_nxt.st = ST_ERASE_FL;
						CMD_WRITE_FLASH: begin
							s_nxt.ee_op = 1'b0;
							s_nxt.st    = i_byte_select_low_high ? ST_IDLE : ST_PROG;
						end
						CMD_WRITE_EE: begin
							s_nxt.ee_op = 1'b1;
							s_nxt.st    = i_byte_select_low_high ? ST_IDLE : ST_PROG;
						end
						CMD_WRITE_FUSE: begin
							if (i_byte_select_low_high) begin
								s_nxt.fuse_hi = s_r.data_lo;
							end else begin
								s_nxt.fuse_lo = s_r.data_lo;
							end
							s_nxt.st = ST_SETTLE;
						end
						CMD_WRITE_LOCK: begin
							s_nxt.lock = s_r.lock & s_r.data_lo;
							s_nxt.st   = ST_SETTLE;
						end
						default: s_nxt.st = ST_IDLE;
					endcase
				end
			end
			ST_ERASE_FL: begin
				s_nxt.idx = s_r.idx + 13'h0001;
				if (s_r.idx == FLASH_LAST) begin
					s_nxt.idx = 13'h0000;
					s_nxt.st  = preserve_ee ? ST_ERASE_LOCK : ST_ERASE_EE;
				end
			end
			ST_ERASE_EE: begin
				s_nxt.idx = s_r.idx + 13'h0001;
				if (s_r.idx == EE_LAST) begin
					s_nxt.st = ST_ERASE_LOCK;
				end
			end
			ST_ERASE_LOCK: begin
				s_nxt.lock = LOCK_RESET;
				s_nxt.st   = ST_SETTLE;
			end
			ST_PROG: begin
				s_nxt.idx = s_r.idx + 13'h0001;
				if (s_r.idx == (s_r.ee_op ? EE_PAGE_LAST : PAGE_LAST)) begin
					s_nxt.st = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				s_nxt.settle = s_r.settle + 8'h01;
				if (s_r.settle == SETTLE_CYCLES - 8'h01) begin
					s_nxt.st = ST_IDLE;
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase

		s_nxt.ready_busy = (s_nxt.st == ST_IDLE) && fifo_in_ready;
		s_nxt.data_oe    = s_r.mode && !i_output_enable_n;
		s_nxt.data_out   = rd_byte;
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_r            <= '0;
			s_r.st         <= ST_IDLE;
			s_r.hv_d       <= 1'b1;
			s_r.xtal_d     <= 1'b1;
			s_r.wr_d       <= 1'b1;
			s_r.pl_d       <= 1'b1;
			s_r.fuse_lo    <= FUSE_LO_RESET;
			s_r.fuse_hi    <= FUSE_HI_RESET;
			s_r.lock       <= LOCK_RESET;
			s_r.ready_busy <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_data_out         = s_r.data_out;
	assign o_data_oe          = s_r.data_oe;
	assign o_ready_busy       = s_r.ready_busy;
	assign o_programming_mode = s_r.mode;

	// Checks
	property p_erase_busy;
		@(posedge i_clock) disable iff (i_sys_rst)
		(wr_ok && s_r.cmd == CMD_CHIP_ERASE) |=> !o_ready_busy [*8];
	endproperty
	a_erase_busy: assert property (p_erase_busy) else $error("busy not low on erase");

	property p_oe_follows;
		@(posedge i_clock) disable iff (i_sys_rst)
		(s_r.mode && i_output_enable_n) |=> !o_data_oe;
	endproperty
	a_oe_follows: assert property (p_oe_follows) else $error("bus driven with oe high");

	property p_addr_lo_load;
		@(posedge i_clock) disable iff (i_sys_rst)
		(xtal_ok && act == ACT_ADDR && !i_byte_select_low_high)
			|=> s_r.addr_lo == $past(i_data_in) && $stable(s_r.addr_hi);
	endproperty
	a_addr_lo_load: assert property (p_addr_lo_load) else $error("address low not loaded");

	property p_idle_action;
		@(posedge i_clock) disable iff (i_sys_rst)
		(xtal_ok && act == 2'h3) |=> $stable(s_r.cmd) && $stable(s_r.addr_lo)
			&& $stable(s_r.data_lo);
	endproperty
	a_idle_action: assert property (p_idle_action) else $error("idle action changed state");

	property p_busy_ignores;
		@(posedge i_clock) disable iff (i_sys_rst)
		(busy && i_crystal_input_strobe && !s_r.xtal_d) |=> $stable(s_r.cmd)
			&& $stable(s_r.addr_lo) && $stable(s_r.addr_hi);
	endproperty
	a_busy_ignores: assert property (p_busy_ignores) else $error("load taken while busy");

	property p_lock_after_flash;
		@(posedge i_clock) disable iff (i_sys_rst)
		(s_r.st == ST_ERASE_FL || s_r.st == ST_ERASE_EE) |=> $stable(s_r.lock)
			&& $stable(s_r.fuse_lo) && $stable(s_r.fuse_hi);
	endproperty
	a_lock_after_flash: assert property (p_lock_after_flash) else $error("lock cleared early");

	property p_ee_preserved;
		@(posedge i_clock) disable iff (i_sys_rst)
		(s_r.st == ST_ERASE_EE) |-> s_r.fuse_hi[FUSE_EEPROM_PRESERVE_FUSE_BIT];
	endproperty
	a_ee_preserved: assert property (p_ee_preserved) else $error("EEPROM erased though kept");

	property p_sig_read;
		@(posedge i_clock) disable iff (i_sys_rst)
		(s_r.mode && s_r.cmd == CMD_READ_SIG && !i_byte_select_low_high
			&& s_r.addr_lo == 8'h00) |=> o_data_out == SIG_BYTE0;
	endproperty
	a_sig_read: assert property (p_sig_read) else $error("signature byte wrong");

	property p_page_length;
		@(posedge i_clock) disable iff (i_sys_rst)
		(s_r.st == ST_PROG && !s_r.ee_op && s_r.idx == 13'h0000)
			|-> ##63 (s_r.st == ST_PROG) ##1 (s_r.st == ST_SETTLE);
	endproperty
	a_page_length: assert property (p_page_length) else $error("page program length wrong");
endmodule // prog_port

`default_nettype wire

//--- prog_fifo.sv
// Staging FIFO between page-load strobes and the page buffers
// Assumes one clock; full and empty reported honestly through ready and valid
`default_nettype none
`timescale 1ns/100ps

module prog_fifo #(
	parameter int WIDTH = 23,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_sys_rst,
	// Fill side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
	} fifo_state_t;

	fifo_state_t f_r;
	fifo_state_t f_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	assign o_in_ready  = (f_r.count != CW'(DEPTH));
	assign o_out_valid = (f_r.count != '0);
	assign o_out_data  = mem[f_r.rd_ptr];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		f_nxt = f_r;
		if (push) begin
			f_nxt.wr_ptr = (f_r.wr_ptr == PW'(DEPTH - 1)) ? '0 : f_r.wr_ptr + PW'(1);
		end
		if (pop) begin
			f_nxt.rd_ptr = (f_r.rd_ptr == PW'(DEPTH - 1)) ? '0 : f_r.rd_ptr + PW'(1);
		end
		if (push && !pop) begin
			f_nxt.count = f_r.count + CW'(1);
		end else if (pop && !push) begin
			f_nxt.count = f_r.count - CW'(1);
		end
	end

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem[f_r.wr_ptr] <= i_in_data;
		end
	end

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			f_r <= '0;
		end else begin
			f_r <= f_nxt;
		end
	end
endmodule // prog_fifo

`default_nettype wire

//--- prog_programmer.sv
// Behavioural external programmer that drives every programming pin
// Assumes the bench forms the data bus level and samples readback on o_take
`default_nettype none
`timescale 1ns/100ps

module prog_programmer (
	// Clock and status
	input  wire logic       i_clock,
	input  wire logic       i_ready_busy,
	// Programming pins
	output logic            o_high_voltage_reset,
	output logic            o_crystal_input_strobe,
	output logic [1:0]      o_action_select,
	output logic            o_byte_select_low_high,
	output logic            o_byte_select_extended,
	output logic            o_page_load_strobe,
	output logic            o_write_n,
	output logic            o_output_enable_n,
	output logic [7:0]      o_data,
	// Readback sample point
	output logic            o_take
);
	localparam int PULSE_CYC = 13; // 260 ns strobes
	int busy_cnt;

	initial begin
		{o_high_voltage_reset, o_crystal_input_strobe, o_page_load_strobe} = 3'h0;
		{o_byte_select_low_high, o_byte_select_extended, o_take} = 3'h0;
		{o_action_select, o_write_n, o_output_enable_n} = 4'hf;
		o_data = 8'h00;
	end

	always @(posedge i_clock) begin
		if (!i_ready_busy) begin
			busy_cnt <= busy_cnt + 1;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(negedge i_clock);
	endtask

	task automatic pulse_xtal();
		tick(1);
		o_crystal_input_strobe = 1'b1;
		tick(PULSE_CYC);
		o_crystal_input_strobe = 1'b0;
		tick(1);
	endtask

	task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
		tick(1);
		o_action_select = act;
		o_byte_select_low_high = bs;
		o_data = d;
		pulse_xtal();
		o_data = ~d;
	endtask

	task automatic page(input logic bs);
		tick(1);
		o_byte_select_low_high = bs;
		tick(1);
		o_page_load_strobe = 1'b1;
		tick(PULSE_CYC);
		o_page_load_strobe = 1'b0;
	endtask

	task automatic write(input logic bs, input logic meddle, output int len);
		int start;
		tick(1);
		o_byte_select_low_high = bs;
		start = busy_cnt;
		tick(1);
		o_write_n = 1'b0;
		tick(PULSE_CYC);
		o_write_n = 1'b1;
		if (meddle) begin
			load(2'h0, 1'b0, 8'h00);
		end
		len = -1;
		for (int i = 0; i < 20000 && len < 0; i++) begin
			tick(1);
			if (i_ready_busy) begin
				len = busy_cnt - start;
			end
		end
	endtask

	task automatic read(input logic bs, input logic ext);
		tick(1);
		o_byte_select_low_high = bs;
		o_byte_select_extended = ext;
		o_output_enable_n = 1'b0;
		tick(2);
		o_take = 1'b1;
		tick(1);
		o_take = 1'b0;
		o_output_enable_n = 1'b1;
		tick(2);
	endtask

	task automatic enter(input logic bad);
		tick(1);
		o_high_voltage_reset = 1'b0;
		{o_page_load_strobe, o_action_select, o_byte_select_low_high} = 4'h0;
		repeat (6) pulse_xtal();
		tick(6);
		o_high_voltage_reset = 1'b1;
		if (bad) begin
			tick(2);
			o_byte_select_low_high = 1'b1;
			tick(1);
			o_byte_select_low_high = 1'b0;
		end
		tick(10);
	endtask

	task automatic leave();
		tick(1);
		o_high_voltage_reset = 1'b0;
		tick(3);
	endtask
endmodule // prog_programmer

`default_nettype wire

//--- tb_prog_port.sv
// Self-checking bench for the programming port and its staging FIFO
// Assumes the programmer model drives the port pins at the falling edge
`default_nettype none
`timescale 1ns/100ps

module tb_prog_port;
	import prog_port_pkg::*;
	localparam logic [7:0] SIG_V [3] = '{8'h21, 8'h43, 8'h65}; // Arbitrary values
	localparam logic [7:0] CAL_V [4] = '{8'h17, 8'h2e, 8'h45, 8'h5c};
	localparam int         ST        = int'(SETTLE_CYCLES);
	logic        i_clock, i_sys_rst, hv, xtal, bs, ext, pl, wr_n, oe_n, take;
	logic [1:0]  act;
	logic [7:0]  prog_data, bus, o_data_out;
	logic        o_data_oe, o_ready_busy, o_programming_mode;
	logic [7:0]  exp_q [$];
	logic [7:0]  d [5];
	logic [15:0] w [FIFO_DEPTH];
	logic [31:0] seed = 32'hc1e6_0c6d;
	int          bad_count, n_checks, len;

	assign bus = o_data_oe ? o_data_out : prog_data;

	prog_programmer i_prog_programmer (.i_clock(i_clock), .i_ready_busy(o_ready_busy),
		.o_high_voltage_reset(hv), .o_crystal_input_strobe(xtal), .o_action_select(act),
		.o_byte_select_low_high(bs), .o_byte_select_extended(ext), .o_page_load_strobe(pl),
		.o_write_n(wr_n), .o_output_enable_n(oe_n), .o_data(prog_data), .o_take(take));

	prog_port #(.SIG_BYTE0(SIG_V[0]), .SIG_BYTE1(SIG_V[1]), .SIG_BYTE2(SIG_V[2]),
		.CAL_BYTE0(CAL_V[0]), .CAL_BYTE1(CAL_V[1]), .CAL_BYTE2(CAL_V[2]),
		.CAL_BYTE3(CAL_V[3])) i_prog_port (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
		.i_high_voltage_reset(hv), .i_crystal_input_strobe(xtal),
		.i_action_select_bit0(act[0]), .i_action_select_bit1(act[1]),
		.i_byte_select_low_high(bs), .i_byte_select_extended(ext), .i_page_load_strobe(pl),
		.i_write_n(wr_n), .i_output_enable_n(oe_n), .i_data_in(bus),
		.o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_ready_busy(o_ready_busy),
		.o_programming_mode(o_programming_mode));

	function automatic logic [7:0] rnd8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic complete_run();
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cmp1(input string nm, input logic e, input logic s);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", nm, e, s);
		end
	endtask

	task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] v);
		i_prog_programmer.load(a, b, v);
	endtask

	task automatic rd(input logic b, input logic x, input logic [7:0] e);
		exp_q.push_back(e);
		i_prog_programmer.read(b, x);
	endtask

	task automatic do_write(input logic b, input logic m, input int n);
		i_prog_programmer.write(b, m, len);
		if (len < 0) begin
			cmp1("ready wait", 1'b1, 1'b0);
			complete_run();
		end else begin
			cmp1("busy cycles", 1'b1, 1'(len >= n && len <= n + 3));
		end
	endtask

	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end

	always @(posedge i_clock) begin
		if (take) begin
			cmp1("drive enable", 1'b1, o_data_oe);
			cmp8("readback", exp_q.pop_front(), o_data_out);
		end
	end

	initial begin
		repeat (60000) @(posedge i_clock);
		cmp1("run time", 1'b1, 1'b0);
		complete_run();
	end

	initial begin
		i_sys_rst = 1'b1;
		repeat (12) @(negedge i_clock);
		i_sys_rst = 1'b0;
		cmp1("ready", 1'b1, o_ready_busy);
		i_prog_programmer.enter(1'b1);
		cmp1("mode", 1'b0, o_programming_mode);
		i_prog_programmer.enter(1'b0);
		cmp1("mode", 1'b1, o_programming_mode);
		ld(ACT_CMD, 1'b0, CMD_READ_FUSE);
		rd(1'b0, 1'b0, FUSE_LO_RESET);
		rd(1'b1, 1'b1, FUSE_HI_RESET);
		rd(1'b1, 1'b0, LOCK_RESET);
		rd(1'b0, 1'b1, ERASED_BYTE);
		cmp1("drive enable", 1'b0, o_data_oe);
		ld(ACT_CMD, 1'b0, CMD_READ_SIG);
		for (int i = 0; i < 3; i++) begin
			ld(ACT_ADDR, 1'b0, 8'(i));
			rd(1'b0, 1'b0, SIG_V[i]);
			rd(1'b1, 1'b0, CAL_V[i]);
		end
		foreach (d[i]) d[i] = rnd8();
		ld(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
		do_write(1'b0, 1'b0, FLASH_WORDS + EE_BYTES + 1 + ST);
		ld(ACT_CMD, 1'b0, CMD_WRITE_FLASH);
		ld(ACT_ADDR, 1'b1, 8'h05);
		ld(ACT_ADDR, 1'b0, 8'h80);
		ld(ACT_DATA, 1'b0, d[0]);
		ld(ACT_DATA, 1'b1, d[1]);
		i_prog_programmer.page(1'b1);
		ld(ACT_ADDR, 1'b0, 8'hbf);
		ld(ACT_DATA, 1'b0, d[2]);
		ld(ACT_DATA, 1'b1, d[3]);
		i_prog_programmer.page(1'b1);
		do_write(1'b0, 1'b1, PAGE_WORDS + ST);
		ld(ACT_CMD, 1'b0, CMD_READ_FLASH);
		rd(1'b0, 1'b0, d[2]);
		rd(1'b1, 1'b0, d[3]);
		ld(ACT_ADDR, 1'b0, 8'h80);
		rd(1'b0, 1'b0, d[0]);
		rd(1'b1, 1'b0, d[1]);
		ld(ACT_CMD, 1'b0, CMD_WRITE_EE);
		ld(ACT_ADDR, 1'b1, 8'h00);
		ld(ACT_ADDR, 1'b0, 8'h05);
		ld(ACT_DATA, 1'b0, d[4]);
		i_prog_programmer.page(1'b0);
		do_write(1'b0, 1'b0, EE_PAGE_BYTES + ST);
		ld(ACT_CMD, 1'b0, CMD_READ_EE);
		ld(2'h3, 1'b0, CMD_READ_FLASH);
		rd(1'b0, 1'b0, d[4]);
		ld(ACT_CMD, 1'b0, CMD_WRITE_LOCK);
		ld(ACT_DATA, 1'b0, 8'hfc);
		do_write(1'b0, 1'b0, ST);
		ld(ACT_CMD, 1'b0, CMD_WRITE_FUSE);
		ld(ACT_DATA, 1'b0, FUSE_HI_RESET & ~(8'h01 << FUSE_EEPROM_PRESERVE_FUSE_BIT));
		do_write(1'b1, 1'b0, ST);
		ld(ACT_DATA, 1'b0, FUSE_LO_RESET & 8'hf0);
		do_write(1'b0, 1'b0, ST);
		ld(ACT_CMD, 1'b0, CMD_READ_FUSE);
		rd(1'b0, 1'b0, FUSE_LO_RESET & 8'hf0);
		rd(1'b1, 1'b0, 8'hfc);
		rd(1'b1, 1'b1, FUSE_HI_RESET & ~(8'h01 << FUSE_EEPROM_PRESERVE_FUSE_BIT));
		ld(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
		do_write(1'b0, 1'b0, FLASH_WORDS + 1 + ST);
		ld(ACT_CMD, 1'b0, CMD_READ_FUSE);
		rd(1'b1, 1'b0, LOCK_RESET);
		rd(1'b0, 1'b0, FUSE_LO_RESET & 8'hf0);
		ld(ACT_CMD, 1'b0, CMD_READ_EE);
		rd(1'b0, 1'b0, d[4]);
		ld(ACT_CMD, 1'b0, CMD_READ_FLASH);
		rd(1'b0, 1'b0, ERASED_BYTE);
		ld(ACT_CMD, 1'b0, CMD_WRITE_FLASH);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			w[i] = {rnd8(), rnd8() & 8'hfe};
			ld(ACT_ADDR, 1'b0, 8'h80 + 8'(i));
			ld(ACT_DATA, 1'b0, w[i][7:0]);
			ld(ACT_DATA, 1'b1, w[i][15:8]);
			i_prog_programmer.page(1'b1);
			cmp1("page ready", 1'b1, o_ready_busy);
		end
		do_write(1'b0, 1'b0, PAGE_WORDS + ST);
		ld(ACT_CMD, 1'b0, CMD_READ_FLASH);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			ld(ACT_ADDR, 1'b0, 8'h80 + 8'(i));
			rd(1'b0, 1'b0, w[i][7:0]);
			rd(1'b1, 1'b0, w[i][15:8]);
		end
		i_prog_programmer.leave();
		cmp1("mode", 1'b0, o_programming_mode);
		cmp1("queue", 1'b1, 1'(exp_q.size() == 0));
		complete_run();
	end
endmodule // tb_prog_port

`default_nettype wire
